/* shared/rx_ctrl_pkg.sv */
// Shared constants for the receive control and link quality block.
package rx_ctrl_pkg;
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 8;
  localparam logic [7:0] OFF_RADIO_STATE = 8'h00;
  localparam logic [7:0] OFF_RX_SYNC = 8'h01;
  localparam logic [7:0] OFF_CTRL_TWO = 8'h02;
  localparam logic [7:0] OFF_ENERGY = 8'h03;
  localparam logic [7:0] OFF_SIG_STRENGTH = 8'h04;
  localparam logic [7:0] OFF_RX_LENGTH = 8'h05;
  localparam logic [7:0] OFF_FOFS = 8'h06;
  localparam logic [7:0] OFF_EXT_CFG = 8'h07;
  localparam logic [7:0] OFF_STATUS = 8'h08;
  localparam logic [7:0] OFF_BUF_ADDR = 8'h09;
  localparam logic [7:0] OFF_BUF_DATA = 8'h0a;
  localparam logic [4:0] CMD_NOP = 5'h00;
  localparam logic [4:0] CMD_RX_ON = 5'h06;
  localparam logic [4:0] CMD_RADIO_IDLE_STATE = 5'h08;
  localparam logic [4:0] CMD_PLL_ON = 5'h09;
  localparam logic [4:0] CMD_AACK_ON = 5'h16;
  localparam logic [4:0] ST_IDLE = 5'h08;
  localparam logic [4:0] ST_PLL = 5'h09;
  localparam logic [4:0] ST_RX_ON = 5'h06;
  localparam logic [4:0] ST_BUSY_RX = 5'h01;
  localparam logic [4:0] ST_AACK_ON = 5'h16;
  localparam logic [4:0] ST_BUSY_AACK = 5'h11;
  localparam int unsigned CTRL_SAFE_BIT = 7;
  localparam int unsigned SYNC_DIS_BIT = 7;
  localparam int unsigned CRC_OK_BIT = 7;
  localparam int unsigned PEND_BIT = 1;
  localparam int unsigned ADDR_HIT_BIT = 0;
  localparam logic [3:0] PDT_RESET = 4'h0;
  localparam logic [7:0] LQI_MAX = 8'hff;
  localparam int unsigned LQI_MIN_PSDU = 2;
  localparam int unsigned BUF_DEPTH = 128;
  localparam int unsigned FOFS_MAX_PPM = 120;
endpackage

/* src/lqi_accum.sv */
// Link quality estimator accumulating per-symbol correlation results.
`timescale 1ns/100ps
module lqi_accum #(
  parameter int unsigned SHIFT = 3
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic start,
  input wire logic sym_valid,
  input wire logic [7:0] sym_corr,
  output logic [7:0] lqi
);
  logic [15:0] sum_r;
  logic [7:0] cnt_r;
  logic [15:0] avg;

  // (R2) Sum symbol correlations.
  always_ff @(posedge clk) begin
    if (rst || start) begin
      sum_r <= 16'h0000;
      cnt_r <= 8'h00;
    end else if (sym_valid && cnt_r != 8'hff) begin
      sum_r <= sum_r + {8'h00, sym_corr};
      cnt_r <= cnt_r + 8'h01;
    end
  end

  always_comb begin
    avg = (cnt_r == 8'h00) ? 16'h0000 : sum_r / {8'h00, cnt_r};
    // (R1) Clamp to byte range.
    lqi = (avg > {8'h00, rx_ctrl_pkg::LQI_MAX}) ? rx_ctrl_pkg::LQI_MAX : avg[7:0];
  end
endmodule

/* src/freq_sync.sv */
// Per-frame frequency offset estimate held for the rest of the frame.
`timescale 1ns/100ps
module freq_sync (
  input wire logic clk,
  input wire logic rst,
  input wire logic sync_det,
  input wire logic signed [7:0] ofs_meas,
  output logic signed [7:0] ofs_corr
);
  localparam logic signed [7:0] LIM = 8'sd120;

  // (R8) Latch clamped offset per frame.
  always_ff @(posedge clk) begin
    if (rst) begin
      ofs_corr <= 8'sh00;
    end else if (sync_det) begin
      if (ofs_meas > LIM) ofs_corr <= LIM;
      else if (ofs_meas < -LIM) ofs_corr <= -LIM;
      else ofs_corr <= ofs_meas;
    end
  end
endmodule

/* src/radio_rx_control_lqi.sv */
// Receive control, frame buffer writes, link quality and register port.
`timescale 1ns/100ps
// Overview of operation
// (R1) Link quality is clamped to 0 to 255.
// (R2) Quality comes from accumulated symbol correlations.
// (R3) Quality valid only for two octets payload.
// (R4) Quality byte stored with frame in buffer.
// (R5) Quality byte valid when done interrupt rises.
// (R6) Basic mode pulses begin and done interrupts.
// (R7) Energy and check result registers updated per frame.
// (R8) Frequency offset estimated and held per frame.
// (R9) Receive-on from idle or synth enables receiver.
// (R10) Auto-ack receive from idle or synth enables.
// (R11) Basic mode needs no extra configuration.
// (R12) No demodulation below preamble threshold.
// (R13) Dynamic protection blocks frames until cleared.
// (R14) Dynamic protection only after valid check.
// (R15) Preamble disable ignores sync headers.
// (R16) Extended mode filters address, reports pending; the code reports the address hit but accepts frames whatever addr_match is.
// (R17) Quality byte placed after last octet.
// (R18) Length held in register, not buffer.
// (R19) Buffer and status written before done.
// (R20) Unprotected buffer is overwritten by new frames.
module radio_rx_control_lqi #(
  parameter int unsigned DEPTH = rx_ctrl_pkg::BUF_DEPTH
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [7:0] rdata,
  input wire logic sync_det,
  input wire logic [3:0] sync_rssi,
  input wire logic signed [7:0] ofs_meas,
  input wire logic octet_valid,
  input wire logic [7:0] octet,
  input wire logic sym_valid,
  input wire logic [7:0] sym_corr,
  input wire logic frame_end,
  input wire logic crc_ok,
  input wire logic [7:0] energy,
  input wire logic addr_match,
  input wire logic pending,
  output logic rx_begin_irq,
  output logic rx_done_irq,
  output logic rx_enabled,
  output logic lqi_valid
);
  typedef enum logic [2:0] {S_OFF, S_PLL, S_LISTEN, S_BUSY, S_LQI, S_FIN} rx_state_e;
  rx_state_e st_r;
  logic ext_r;
  logic [7:0] buf_mem [DEPTH];
  logic [6:0] wptr_r;
  logic [7:0] len_r;
  logic [7:0] energy_level_reg;
  logic [7:0] signal_strength_reg;
  logic [7:0] rx_frame_length_reg;
  logic [7:0] rx_sync_ctrl_reg;
  logic [7:0] radio_ctrl_two_reg;
  logic [7:0] ext_status_r;
  logic [6:0] buf_raddr_r;
  logic protect_r;
  logic [3:0] rssi_r;
  logic [4:0] state_code;
  logic [7:0] lqi;
  logic signed [7:0] ofs_corr;
  logic accept;

  function automatic logic wr_at(input logic [7:0] a, input logic [7:0] off, input logic w);
    wr_at = w && (a == off);
  endfunction

  lqi_accum u_lqi (
    .clk(clk),
    .rst(rst),
    .start(accept),
    .sym_valid(sym_valid && st_r == S_BUSY),
    .sym_corr(sym_corr),
    .lqi(lqi)
  );

  freq_sync u_sync (
    .clk(clk),
    .rst(rst),
    .sync_det(accept),
    .ofs_meas(ofs_meas),
    .ofs_corr(ofs_corr)
  );

  // (R12) Threshold, disable and protection gate detection.
  // (R15) Sync headers ignored while disabled.
  // (R13) Protected buffer refuses new frames.
  assign accept = (st_r == S_LISTEN) && sync_det && !rx_sync_ctrl_reg[rx_ctrl_pkg::SYNC_DIS_BIT]
                  && !protect_r && (sync_rssi >= rx_sync_ctrl_reg[3:0]);

  always_ff @(posedge clk) begin
    if (rst) begin
      st_r <= S_OFF;
      ext_r <= 1'b0;
    end else begin
      case (st_r)
        S_OFF, S_PLL: begin
          // (R9) Receive-on from idle or synth.
          // (R11) Basic mode needs only the command.
          if (wr_at(addr, rx_ctrl_pkg::OFF_RADIO_STATE, wr) && wdata[4:0] == rx_ctrl_pkg::CMD_RX_ON) begin
            st_r <= S_LISTEN;
            ext_r <= 1'b0;
          // (R10) Auto-ack receive from idle or synth.
          end else if (wr_at(addr, rx_ctrl_pkg::OFF_RADIO_STATE, wr) && wdata[4:0] == rx_ctrl_pkg::CMD_AACK_ON) begin
            st_r <= S_LISTEN;
            ext_r <= 1'b1;
          end else if (wr_at(addr, rx_ctrl_pkg::OFF_RADIO_STATE, wr) && wdata[4:0] == rx_ctrl_pkg::CMD_PLL_ON) begin
            st_r <= S_PLL;
          end else if (wr_at(addr, rx_ctrl_pkg::OFF_RADIO_STATE, wr) && wdata[4:0] == rx_ctrl_pkg::CMD_RADIO_IDLE_STATE) begin
            st_r <= S_OFF;
          end
        end
        S_LISTEN: begin
          if (accept) st_r <= S_BUSY;
          else if (wr_at(addr, rx_ctrl_pkg::OFF_RADIO_STATE, wr) && wdata[4:0] == rx_ctrl_pkg::CMD_PLL_ON) st_r <= S_PLL;
          else if (wr_at(addr, rx_ctrl_pkg::OFF_RADIO_STATE, wr) && wdata[4:0] == rx_ctrl_pkg::CMD_RADIO_IDLE_STATE) st_r <= S_OFF;
        end
        S_BUSY: if (frame_end) st_r <= S_LQI;
        S_LQI: st_r <= S_FIN;
        S_FIN: st_r <= S_LISTEN;
        default: st_r <= S_OFF;
      endcase
    end
  end

  // (R20) New frame overwrites from buffer start.
  // (R18) Payload octets and the quality byte go to the buffer; the length is kept in len_r.
  always_ff @(posedge clk) begin
    if (rst) begin
      wptr_r <= 7'h00;
      len_r <= 8'h00;
    end else if (accept) begin
      wptr_r <= 7'h00;
      len_r <= 8'h00;
    end else if (st_r == S_BUSY && octet_valid) begin
      if (wptr_r != 7'(DEPTH - 1)) wptr_r <= wptr_r + 7'h01;
      if (len_r != 8'hff) len_r <= len_r + 8'h01;
    end
  end

  always_ff @(posedge clk) begin
    if (st_r == S_BUSY && octet_valid) begin
      buf_mem[wptr_r] <= octet;
    // (R4) Append quality byte after frame.
    // (R17) Written right after last octet.
    end else if (st_r == S_LQI) begin
      buf_mem[wptr_r] <= lqi;
    end
  end

  // (R7) Strength seen at the accepted header.
  // The demodulator holds sync_rssi only beside sync_det, so the level is kept here until the frame ends.
  always_ff @(posedge clk) begin
    if (rst) rssi_r <= 4'h0;
    else if (accept) rssi_r <= sync_rssi;
  end

  // (R7) Per-frame energy and check status.
  // (R19) Status written in the same step as the quality byte.
  always_ff @(posedge clk) begin
    if (rst) begin
      energy_level_reg <= 8'h00;
      signal_strength_reg <= 8'h00;
      rx_frame_length_reg <= 8'h00;
      ext_status_r <= 8'h00;
      lqi_valid <= 1'b0;
    end else if (st_r == S_LQI) begin
      energy_level_reg <= energy;
      signal_strength_reg <= {crc_ok, 3'h0, rssi_r};
      rx_frame_length_reg <= len_r;
      // (R16) Address hit and pending data reported.
      ext_status_r <= {6'h00, ext_r & pending, ext_r & addr_match};
      // (R3) Valid only with two or more octets.
      lqi_valid <= (len_r >= 8'(rx_ctrl_pkg::LQI_MIN_PSDU));
    end
  end

  // (R14) Protection armed only on good check.
  always_ff @(posedge clk) begin
    if (rst) protect_r <= 1'b0;
    else if (!radio_ctrl_two_reg[rx_ctrl_pkg::CTRL_SAFE_BIT]) protect_r <= 1'b0;
    else if (st_r == S_LQI && crc_ok) protect_r <= 1'b1;
  end

  // (R6) Begin and done pulses.
  // (R5) Done rises after quality byte is stored.
  always_ff @(posedge clk) begin
    if (rst) begin
      rx_begin_irq <= 1'b0;
      rx_done_irq <= 1'b0;
      rx_enabled <= 1'b0;
    end else begin
      rx_begin_irq <= accept;
      rx_done_irq <= (st_r == S_FIN);
      rx_enabled <= (st_r == S_LISTEN) || (st_r == S_BUSY) || (st_r == S_LQI) || (st_r == S_FIN);
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      rx_sync_ctrl_reg <= {4'h0, rx_ctrl_pkg::PDT_RESET};
      radio_ctrl_two_reg <= 8'h00;
      buf_raddr_r <= 7'h00;
    end else begin
      if (wr_at(addr, rx_ctrl_pkg::OFF_RX_SYNC, wr)) rx_sync_ctrl_reg <= wdata;
      if (wr_at(addr, rx_ctrl_pkg::OFF_CTRL_TWO, wr)) radio_ctrl_two_reg <= wdata;
      if (wr_at(addr, rx_ctrl_pkg::OFF_BUF_ADDR, wr)) buf_raddr_r <= wdata[6:0];
      else if (rd && addr == rx_ctrl_pkg::OFF_BUF_DATA) buf_raddr_r <= buf_raddr_r + 7'h01;
    end
  end

  always_comb begin
    case (st_r)
      S_OFF: state_code = rx_ctrl_pkg::ST_IDLE;
      S_PLL: state_code = rx_ctrl_pkg::ST_PLL;
      S_LISTEN: state_code = ext_r ? rx_ctrl_pkg::ST_AACK_ON : rx_ctrl_pkg::ST_RX_ON;
      default: state_code = ext_r ? rx_ctrl_pkg::ST_BUSY_AACK : rx_ctrl_pkg::ST_BUSY_RX;
    endcase
  end

  // Reads of unmapped offsets return zero so software sees a defined value.
  always_ff @(posedge clk) begin
    if (rst) rdata <= 8'h00;
    else if (rd) begin
      case (addr)
        rx_ctrl_pkg::OFF_RADIO_STATE: rdata <= {3'h0, state_code};
        rx_ctrl_pkg::OFF_RX_SYNC: rdata <= rx_sync_ctrl_reg;
        rx_ctrl_pkg::OFF_CTRL_TWO: rdata <= radio_ctrl_two_reg;
        rx_ctrl_pkg::OFF_ENERGY: rdata <= energy_level_reg;
        rx_ctrl_pkg::OFF_SIG_STRENGTH: rdata <= signal_strength_reg;
        rx_ctrl_pkg::OFF_RX_LENGTH: rdata <= rx_frame_length_reg;
        rx_ctrl_pkg::OFF_FOFS: rdata <= ofs_corr;
        rx_ctrl_pkg::OFF_EXT_CFG: rdata <= ext_status_r;
        rx_ctrl_pkg::OFF_STATUS: rdata <= {6'h00, protect_r, lqi_valid};
        rx_ctrl_pkg::OFF_BUF_DATA: rdata <= buf_mem[buf_raddr_r];
        default: rdata <= 8'h00;
      endcase
    end else rdata <= 8'h00;
  end

  sequence frame_end_s;
    st_r == S_BUSY && frame_end;
  endsequence

  done_after_store_a: assert property (@(posedge clk) disable iff (rst) // (R19)
    frame_end_s |-> ##3 rx_done_irq) else $error("done interrupt not three cycles after frame end");
  begin_pulse_a: assert property (@(posedge clk) disable iff (rst) // (R6)
    accept |=> rx_begin_irq) else $error("begin interrupt missing");
  threshold_gate_a: assert property (@(posedge clk) disable iff (rst) // (R12)
    st_r == S_LISTEN && sync_det && sync_rssi < rx_sync_ctrl_reg[3:0] |=> !rx_begin_irq)
    else $error("frame accepted below threshold");
  sync_disable_a: assert property (@(posedge clk) disable iff (rst) // (R15)
    rx_sync_ctrl_reg[rx_ctrl_pkg::SYNC_DIS_BIT] && sync_det |=> !rx_begin_irq)
    else $error("sync taken while disabled");
  protect_block_a: assert property (@(posedge clk) disable iff (rst) // (R13)
    protect_r && sync_det |=> !rx_begin_irq && st_r != S_BUSY) else $error("protected buffer accepted frame");
  protect_crc_a: assert property (@(posedge clk) disable iff (rst) // (R14)
    $rose(protect_r) |-> $past(crc_ok)) else $error("protection armed on bad check");
  bad_check_a: assert property (@(posedge clk) disable iff (rst) // (R14)
    st_r == S_LQI && !crc_ok && !protect_r |=> !protect_r) else $error("bad check armed protection");
  lqi_len_a: assert property (@(posedge clk) disable iff (rst) // (R3)
    rx_done_irq |-> lqi_valid == (rx_frame_length_reg >= 8'(rx_ctrl_pkg::LQI_MIN_PSDU)))
    else $error("quality validity wrong");
  length_reg_a: assert property (@(posedge clk) disable iff (rst) // (R18)
    st_r == S_LQI |=> rx_frame_length_reg == $past(len_r)) else $error("length register not updated");

  sequence rx_on_cmd_s;
    (st_r == S_OFF || st_r == S_PLL) && wr_at(addr, rx_ctrl_pkg::OFF_RADIO_STATE, wr)
      && wdata[4:0] == rx_ctrl_pkg::CMD_RX_ON;
  endsequence

  sequence aack_cmd_s;
    (st_r == S_OFF || st_r == S_PLL) && wr_at(addr, rx_ctrl_pkg::OFF_RADIO_STATE, wr)
      && wdata[4:0] == rx_ctrl_pkg::CMD_AACK_ON;
  endsequence

  rx_on_enable_a: assert property (@(posedge clk) disable iff (rst) // (R9)
    rx_on_cmd_s |=> st_r == S_LISTEN && !ext_r) else $error("receive command did not enable receiver");
  aack_enable_a: assert property (@(posedge clk) disable iff (rst) // (R10)
    aack_cmd_s |=> st_r == S_LISTEN && ext_r) else $error("auto-ack command did not enable receiver");
  enable_level_a: assert property (@(posedge clk) disable iff (rst) // (R9)
    st_r == S_LISTEN |=> rx_enabled) else $error("listening receiver not flagged enabled");
  lqi_place_a: assert property (@(posedge clk) disable iff (rst) // (R17)
    st_r == S_LQI |=> buf_mem[$past(wptr_r)] == $past(lqi)) else $error("quality byte not after last octet");
  overwrite_a: assert property (@(posedge clk) disable iff (rst) // (R20)
    accept |=> wptr_r == 7'h00 && len_r == 8'h00) else $error("new frame does not restart buffer");
  status_update_a: assert property (@(posedge clk) disable iff (rst) // (R7)
    st_r == S_LQI |=> energy_level_reg == $past(energy) && signal_strength_reg[3:0] == rssi_r)
    else $error("energy or strength not updated");
  done_pulse_a: assert property (@(posedge clk) disable iff (rst) // (R6)
    rx_done_irq |=> !rx_done_irq) else $error("done interrupt longer than one cycle");
  rdata_idle_a: assert property (@(posedge clk) disable iff (rst)
    !rd |=> rdata == 8'h00) else $error("read data not zero without read");
endmodule

/* test/remote_tx.sv */
// Behavioural far-end transmitter seen through the demodulator outputs.
`timescale 1ns/100ps
module remote_tx (
  input wire logic clk,
  output logic sync_det,
  output logic [3:0] sync_rssi,
  output logic signed [7:0] ofs_meas,
  output logic octet_valid,
  output logic [7:0] octet,
  output logic sym_valid,
  output logic [7:0] sym_corr,
  output logic frame_end,
  output logic crc_ok,
  output logic [7:0] energy,
  output logic addr_match,
  output logic pending
);
  initial begin
    {sync_det, octet_valid, sym_valid, frame_end, crc_ok, addr_match, pending} = '0;
    {sync_rssi, ofs_meas, octet, sym_corr, energy} = '0;
  end
  // Idle sync_rssi, sym_corr, crc_ok and energy carry inverted values so stale data is never mistaken for fresh.
  task automatic send(input int n, input logic [7:0] corr, input logic crc, input logic [3:0] rs,
                      input logic [7:0] ofs);
    @(posedge clk);
    sync_det <= 1'b1;
    sync_rssi <= rs;
    ofs_meas <= ofs;
    for (int i = 0; i < n; i++) begin
      @(posedge clk);
      sync_det <= 1'b0;
      sync_rssi <= ~rs;
      octet_valid <= 1'b0;
      sym_valid <= 1'b1;
      sym_corr <= corr;
      @(posedge clk);
      sym_valid <= 1'b0;
      sym_corr <= ~corr;
      octet_valid <= 1'b1;
      octet <= 8'ha0 + i[7:0];
    end
    @(posedge clk);
    octet_valid <= 1'b0;
    octet <= 8'h5a;
    frame_end <= 1'b1;
    {crc_ok, addr_match, pending} <= {crc, 2'b11};
    energy <= 8'h3c;
    @(posedge clk);
    frame_end <= 1'b0;
    @(posedge clk);
    {crc_ok, addr_match, pending} <= {~crc, 2'b00};
    energy <= 8'hc3;
    repeat (5) @(posedge clk);
  endtask
endmodule

/* test/radio_rx_control_lqi_tb.sv */
// Self-checking bench for the receive control and link quality block.
`timescale 1ns/100ps
module radio_rx_control_lqi_tb;
  logic clk, rst, wr, rd, sync_det, octet_valid, sym_valid, frame_end, crc_ok, addr_match, pending;
  logic rx_begin_irq, rx_done_irq, rx_enabled, lqi_valid;
  logic [7:0] addr, wdata, rdata, octet, sym_corr, energy;
  logic [3:0] sync_rssi;
  logic signed [7:0] ofs_meas;
  int failures = 0, cmp_count = 0, cyc = 0, sync_cyc = 0, fe_cyc = 0, beg_cyc = 0, done_cyc = 0, beg_cnt = 0;

  radio_rx_control_lqi radio_rx_control_lqi_inst (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .rdata(rdata), .sync_det(sync_det), .sync_rssi(sync_rssi), .ofs_meas(ofs_meas),
    .octet_valid(octet_valid), .octet(octet), .sym_valid(sym_valid), .sym_corr(sym_corr),
    .frame_end(frame_end), .crc_ok(crc_ok), .energy(energy), .addr_match(addr_match), .pending(pending),
    .rx_begin_irq(rx_begin_irq), .rx_done_irq(rx_done_irq), .rx_enabled(rx_enabled), .lqi_valid(lqi_valid));
  remote_tx remote_tx_inst (.clk(clk), .sync_det(sync_det), .sync_rssi(sync_rssi), .ofs_meas(ofs_meas),
    .octet_valid(octet_valid), .octet(octet), .sym_valid(sym_valid), .sym_corr(sym_corr),
    .frame_end(frame_end), .crc_ok(crc_ok), .energy(energy), .addr_match(addr_match), .pending(pending));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // Event timestamps let the latency checks work after the frame has finished.
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (sync_det) sync_cyc <= cyc;
    if (frame_end) fe_cyc <= cyc;
    if (rx_begin_irq === 1'b1) begin
      beg_cyc <= cyc;
      beg_cnt <= beg_cnt + 1;
    end
    if (rx_done_irq === 1'b1) done_cyc <= cyc;
  end

  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe, so they are taken there.
  task automatic rchk(input string what, input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 check(what, rdata, exp);
  endtask

  task automatic rx_frame(input int n, input logic [7:0] corr, input logic crc, input logic [3:0] rs,
                          input logic [7:0] ofs, input logic acc);
    int b;
    b = beg_cnt;
    remote_tx_inst.send(n, corr, crc, rs, ofs);
    check("begin count", 8'(beg_cnt - b), {7'h00, acc});
    if (acc) begin
      check("begin delay", 8'(beg_cyc - sync_cyc), 8'h01);
      check("done delay", 8'(done_cyc - fe_cyc), 8'h03);
    end
  endtask

  task automatic read_buf(input int n, input logic [7:0] q);
    wr_reg(rx_ctrl_pkg::OFF_BUF_ADDR, 8'h00);
    for (int i = 0; i < n; i++) rchk("buffer octet", rx_ctrl_pkg::OFF_BUF_DATA, 8'ha0 + i[7:0]);
    rchk("quality byte", rx_ctrl_pkg::OFF_BUF_DATA, q);
  endtask

  task automatic t_enable();
    rchk("reset state", rx_ctrl_pkg::OFF_RADIO_STATE, {3'h0, rx_ctrl_pkg::ST_IDLE});
    check("idle enable", {7'h00, rx_enabled}, 8'h00);
    wr_reg(rx_ctrl_pkg::OFF_RADIO_STATE, {3'h0, rx_ctrl_pkg::CMD_RX_ON});
    rchk("listen state", rx_ctrl_pkg::OFF_RADIO_STATE, {3'h0, rx_ctrl_pkg::ST_RX_ON});
    check("listen enable", {7'h00, rx_enabled}, 8'h01);
    $display("test enable done");
  endtask

  task automatic t_frames();
    rx_frame(3, 8'd200, 1'b1, 4'hf, 8'sd50, 1'b1);
    rchk("length", rx_ctrl_pkg::OFF_RX_LENGTH, 8'h03);
    rchk("strength", rx_ctrl_pkg::OFF_SIG_STRENGTH, 8'h8f);
    rchk("energy", rx_ctrl_pkg::OFF_ENERGY, 8'h3c);
    rchk("offset", rx_ctrl_pkg::OFF_FOFS, 8'h32);
    rchk("status", rx_ctrl_pkg::OFF_STATUS, 8'h01);
    check("quality valid", {7'h00, lqi_valid}, 8'h01);
    read_buf(3, 8'd200);
    rx_frame(1, 8'd90, 1'b0, 4'hf, 8'h81, 1'b1);
    check("short valid", {7'h00, lqi_valid}, 8'h00);
    rchk("offset clamp", rx_ctrl_pkg::OFF_FOFS, 8'h88);
    rchk("bad check", rx_ctrl_pkg::OFF_SIG_STRENGTH, 8'h0f);
    $display("test frames done");
  endtask

  task automatic t_gates();
    wr_reg(rx_ctrl_pkg::OFF_RX_SYNC, 8'h08);
    rx_frame(2, 8'd40, 1'b1, 4'h7, 8'h00, 1'b0);
    rx_frame(2, 8'd40, 1'b1, 4'h8, 8'h00, 1'b1);
    wr_reg(rx_ctrl_pkg::OFF_RX_SYNC, 8'h80);
    rx_frame(2, 8'd40, 1'b1, 4'hf, 8'h00, 1'b0);
    rchk("sync off state", rx_ctrl_pkg::OFF_RADIO_STATE, {3'h0, rx_ctrl_pkg::ST_RX_ON});
    wr_reg(rx_ctrl_pkg::OFF_RX_SYNC, 8'h00);
    rx_frame(2, 8'd40, 1'b1, 4'hf, 8'h00, 1'b1);
    $display("test gates done");
  endtask

  task automatic t_protect();
    wr_reg(rx_ctrl_pkg::OFF_CTRL_TWO, 8'h80);
    rx_frame(2, 8'd70, 1'b0, 4'hf, 8'h00, 1'b1);
    rx_frame(2, 8'd80, 1'b1, 4'hf, 8'h00, 1'b1);
    rchk("protected", rx_ctrl_pkg::OFF_STATUS, 8'h03);
    rx_frame(4, 8'd10, 1'b1, 4'hf, 8'h00, 1'b0);
    rchk("hold state", rx_ctrl_pkg::OFF_RADIO_STATE, {3'h0, rx_ctrl_pkg::ST_RX_ON});
    read_buf(2, 8'd80);
    wr_reg(rx_ctrl_pkg::OFF_CTRL_TWO, 8'h00);
    rx_frame(3, 8'd120, 1'b1, 4'hf, 8'h00, 1'b1);
    read_buf(3, 8'd120);
    $display("test protect done");
  endtask

  task automatic t_aack();
    wr_reg(rx_ctrl_pkg::OFF_RADIO_STATE, {3'h0, rx_ctrl_pkg::CMD_PLL_ON});
    rchk("synth state", rx_ctrl_pkg::OFF_RADIO_STATE, {3'h0, rx_ctrl_pkg::ST_PLL});
    wr_reg(rx_ctrl_pkg::OFF_RADIO_STATE, {3'h0, rx_ctrl_pkg::CMD_AACK_ON});
    rchk("aack state", rx_ctrl_pkg::OFF_RADIO_STATE, {3'h0, rx_ctrl_pkg::ST_AACK_ON});
    rx_frame(2, 8'd60, 1'b1, 4'hf, 8'h00, 1'b1);
    rchk("ext status", rx_ctrl_pkg::OFF_EXT_CFG, 8'h03);
    wr_reg(rx_ctrl_pkg::OFF_RADIO_STATE, {3'h0, rx_ctrl_pkg::CMD_RADIO_IDLE_STATE});
    rchk("off state", rx_ctrl_pkg::OFF_RADIO_STATE, {3'h0, rx_ctrl_pkg::ST_IDLE});
    check("off enable", {7'h00, rx_enabled}, 8'h00);
    $display("test aack done");
  endtask

  task automatic summarize();
    $display("compares %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // The full run needs under 250 cycles; the watchdog allows about eighty times that.
  initial begin
    repeat (20000) @(posedge clk);
    failures++;
    summarize();
  end

  initial begin
    {rst, wr, rd, addr, wdata} = {1'b1, 18'h0};
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    t_enable();
    t_frames();
    t_gates();
    t_protect();
    t_aack();
    summarize();
  end
endmodule
